/* ccpu_pkg.sv */
`default_nettype none
package ccpu_pkg;
  // Bus geometry.
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int AXI_SW = AXI_DW / 8;
  localparam int T1_W = 16;
  localparam int BYTE_W = 8;
  localparam int CTRL_W = 6;
  localparam int PRESC_W = 4;

  // Register byte offsets.
  localparam logic [AXI_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] ADDR_VAL_LOW = 8'h04;
  localparam logic [AXI_AW-1:0] ADDR_VAL_HIGH = 8'h08;
  localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h0C;
  localparam logic [AXI_AW-1:0] ADDR_PERIOD = 8'h10;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Field positions and fixed values.
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_PIN_BIT = 1;
  localparam int STAT_PEND_BIT = 2;
  localparam logic [PRESC_W-1:0] PRESC_ZERO = 4'h0;
  localparam logic [PRESC_W-1:0] PRESC_LAST4 = 4'h3;
  localparam logic [PRESC_W-1:0] PRESC_LAST16 = 4'hF;
  localparam logic [1:0] PWM_SEL = 2'h3;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [9:0] DUTY_ZERO = 10'h000;

  // Operating mode codes; every code with the top two bits set is PWM.
  typedef enum logic [3:0] {
    MODE_OFF = 4'b0000,
    MODE_CMP_TOGGLE = 4'b0010,
    MODE_CAP_FALL = 4'b0100,
    MODE_CAP_RISE = 4'b0101,
    MODE_CAP_RISE4 = 4'b0110,
    MODE_CAP_RISE16 = 4'b0111,
    MODE_CMP_SET = 4'b1000,
    MODE_CMP_CLEAR = 4'b1001,
    MODE_CMP_SWI = 4'b1010,
    MODE_CMP_TRIG = 4'b1011
  } ccpu_mode_e;

  // Module control register layout.
  typedef struct packed {
    logic [1:0] duty_low;
    logic [3:0] mode;
  } ccpu_ctrl_s;

  localparam ccpu_ctrl_s CTRL_RESET = 6'h00;
endpackage
`default_nettype wire

/* ccpu_unit.sv */
`default_nettype none
// Notes on behaviour
// - Pin event copies 16-bit timer one count.
// - Mode picks falling, rising, 4th, 16th rise.
// - Capture sets event flag; software alone clears.
// - Newer capture overwrites stored value.
// - Edge detector watches pin even when driven.
// - Mode change may falsely set flag.
// - Prescaler zero when off, not capture, reset.
// - Prescaler switch keeps count; clear control first.
// - Capture keeps working during sleep.
// - Compare matches 16-bit value, performs action.
// - Every compare match sets the event flag.
// - Software interrupt mode: flag only, pin released.
// - Special trigger resets timer, starts converter.
// - Trigger immediate; timer clear at next tick.
// - Trigger clear never sets overflow flag.
// - Value write before tick cancels clear.
// - Compare stops while system clock sleeps.
// - PWM output with ten-bit duty resolution.
// - Control zero turns off, releases pin.
// - High value byte read-only in PWM.
// - Period end clears timer two, sets pin unless duty is zero, latches duty.
// - Pin clears when time base equals duty.
module ccpu_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ccpu_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ccpu_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [ccpu_pkg::AXI_SW-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ccpu_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [ccpu_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [ccpu_pkg::T1_W-1:0] timer_one_count,
  input wire logic timer_one_tick,
  input wire logic [ccpu_pkg::BYTE_W-1:0] timer_two_count,
  input wire logic [1:0] time_base_low,
  input wire logic timer_two_inc,
  input wire logic sleep_active,
  input wire logic module_io_pin_in,
  output logic module_io_pin_out,
  output logic module_io_pin_oe,
  output logic module_event_flag,
  output logic special_trigger,
  output logic timer_one_clear,
  output logic timer_two_clear
);
  import ccpu_pkg::*;

  ccpu_ctrl_s ctrl_reg;
  logic [BYTE_W-1:0] val_low_reg;
  logic [BYTE_W-1:0] val_high_reg;
  logic [BYTE_W-1:0] period_reg;
  logic [1:0] duty_latch_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_prev_reg;
  logic match_prev_reg;
  logic pend_reg;
  logic flag_reg;
  logic pin_out_reg;
  logic pin_oe_reg;
  logic trig_reg;
  logic t1_clear_reg;
  logic t2_clear_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [AXI_DW-1:0] rdata_reg;
  logic [AXI_AW-1:0] awaddr_reg;
  logic [AXI_DW-1:0] wdata_reg;
  logic wstrb0_reg;

  logic is_cap;
  logic is_cmp;
  logic is_pwm;
  logic drives_pin;
  logic pin_rise;
  logic pin_fall;
  logic cap_evt;
  logic match_now;
  logic cmp_hit;
  logic trig_hit;
  logic period_roll;
  logic duty_match;
  logic [9:0] duty_next;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic aw_got_next;
  logic w_got_next;
  logic rvalid_next;
  logic wr_en;
  logic wr_ctrl;
  logic wr_low;
  logic wr_high;
  logic wr_stat;
  logic wr_per;
  logic wr_ok;
  logic flag_clear;
  logic [AXI_DW-1:0] rd_word;
  logic rd_ok;

  // Mode decode; reserved codes fall to idle so the pin is never left driven.
  always_comb begin
    is_cap = 1'b0;
    is_cmp = 1'b0;
    is_pwm = ctrl_reg.mode[3:2] == PWM_SEL;
    unique case (ctrl_reg.mode)
      MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16: begin
        is_cap = 1'b1;
      end
      MODE_CMP_TOGGLE, MODE_CMP_SET, MODE_CMP_CLEAR, MODE_CMP_SWI, MODE_CMP_TRIG: begin
        is_cmp = 1'b1;
      end
      default: begin
        is_cap = 1'b0;
      end
    endcase
  end

  // Only pin-action compare modes and PWM own the pin.
  assign drives_pin = is_pwm || ctrl_reg.mode == MODE_CMP_TOGGLE
    || ctrl_reg.mode == MODE_CMP_SET || ctrl_reg.mode == MODE_CMP_CLEAR;

  // Pin synchroniser; the pin is read whatever its direction, so port writes can capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= module_io_pin_in;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign pin_rise = pin_sync_reg && !pin_prev_reg;
  assign pin_fall = !pin_sync_reg && pin_prev_reg;

  // Capture event select. Capture runs on the bus clock and ignores sleep.
  always_comb begin
    cap_evt = 1'b0;
    unique case (ctrl_reg.mode)
      MODE_CAP_FALL: cap_evt = pin_fall;
      MODE_CAP_RISE: cap_evt = pin_rise;
      MODE_CAP_RISE4: cap_evt = pin_rise && presc_reg == PRESC_LAST4;
      MODE_CAP_RISE16: cap_evt = pin_rise && presc_reg == PRESC_LAST16;
      default: cap_evt = 1'b0;
    endcase
  end

  // Edge prescaler. Switching between capture codes keeps the count on purpose.
  always_ff @(posedge aclk) begin
    if (!aresetn || !is_cap) begin
      presc_reg <= PRESC_ZERO;
    end else if (cap_evt) begin
      presc_reg <= PRESC_ZERO;
    end else if (pin_rise) begin
      presc_reg <= presc_reg + 1'b1;
    end
  end

  // Compare acts once per match entry; a held match would otherwise retrigger.
  assign match_now = is_cmp && !sleep_active
    && timer_one_count == {val_high_reg, val_low_reg};
  assign cmp_hit = match_now && !match_prev_reg;
  assign trig_hit = cmp_hit && ctrl_reg.mode == MODE_CMP_TRIG;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_prev_reg <= 1'b0;
    end else begin
      match_prev_reg <= match_now;
    end
  end

  // PWM period end and duty match.
  assign period_roll = is_pwm && timer_two_inc && timer_two_count == period_reg;
  assign duty_next = {val_low_reg, ctrl_reg.duty_low};
  assign duty_match = is_pwm
    && {timer_two_count, time_base_low} == {val_high_reg, duty_latch_reg};

  // Event flag: hardware set wins over a software clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= 1'b0;
    end else if (cap_evt || cmp_hit) begin
      flag_reg <= 1'b1;
    end else if (flag_clear) begin
      flag_reg <= 1'b0;
    end
  end

  // Pin driver and its enable.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else begin
      pin_oe_reg <= drives_pin;
      if (cmp_hit) begin
        unique case (ctrl_reg.mode)
          MODE_CMP_TOGGLE: pin_out_reg <= !pin_out_reg;
          MODE_CMP_SET: pin_out_reg <= 1'b1;
          MODE_CMP_CLEAR: pin_out_reg <= 1'b0;
          default: pin_out_reg <= pin_out_reg;
        endcase
      end else if (period_roll) begin
        pin_out_reg <= duty_next != DUTY_ZERO;
      end else if (duty_match) begin
        pin_out_reg <= 1'b0;
      end
    end
  end

  // Special trigger and the deferred timer one clear. The clear is its own
  // strobe, separate from any overflow path, so it never sets that flag.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_reg <= 1'b0;
      pend_reg <= 1'b0;
      t1_clear_reg <= 1'b0;
    end else begin
      trig_reg <= trig_hit;
      t1_clear_reg <= pend_reg && timer_one_tick && !(wr_low || wr_high);
      if (trig_hit) begin
        pend_reg <= 1'b1;
      end else if (timer_one_tick || wr_low || wr_high || !is_cmp) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // Timer two clear and duty low-bit latch at the period end.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t2_clear_reg <= 1'b0;
      duty_latch_reg <= 2'h0;
    end else begin
      t2_clear_reg <= period_roll;
      if (period_roll) begin
        duty_latch_reg <= ctrl_reg.duty_low;
      end
    end
  end

  // Value pair. Capture beats a bus write landing in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      val_low_reg <= BYTE_ZERO;
      val_high_reg <= BYTE_ZERO;
    end else begin
      if (cap_evt) begin
        val_low_reg <= timer_one_count[BYTE_W-1:0];
      end else if (wr_low) begin
        val_low_reg <= wdata_reg[BYTE_W-1:0];
      end
      if (cap_evt) begin
        val_high_reg <= timer_one_count[T1_W-1:BYTE_W];
      end else if (period_roll) begin
        val_high_reg <= val_low_reg;
      end else if (wr_high && !is_pwm) begin
        val_high_reg <= wdata_reg[BYTE_W-1:0];
      end
    end
  end

  // Control and period registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      period_reg <= BYTE_ZERO;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= ccpu_ctrl_s'(wdata_reg[CTRL_W-1:0]);
      end
      if (wr_per) begin
        period_reg <= wdata_reg[BYTE_W-1:0];
      end
    end
  end

  // Write path: address and data are held separately, so either may come first.
  assign aw_take = s_axi_awvalid && awready_reg;
  assign w_take = s_axi_wvalid && wready_reg;
  assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;
  assign aw_got_next = do_write ? 1'b0 : (aw_got_reg || aw_take);
  assign w_got_next = do_write ? 1'b0 : (w_got_reg || w_take);
  assign wr_en = do_write && wstrb0_reg;
  assign wr_ctrl = wr_en && awaddr_reg == ADDR_CTRL;
  assign wr_low = wr_en && awaddr_reg == ADDR_VAL_LOW;
  assign wr_high = wr_en && awaddr_reg == ADDR_VAL_HIGH;
  assign wr_stat = wr_en && awaddr_reg == ADDR_STATUS;
  assign wr_per = wr_en && awaddr_reg == ADDR_PERIOD;
  assign flag_clear = wr_stat && wdata_reg[STAT_FLAG_BIT];
  assign wr_ok = awaddr_reg == ADDR_CTRL || awaddr_reg == ADDR_VAL_LOW
    || awaddr_reg == ADDR_VAL_HIGH || awaddr_reg == ADDR_STATUS
    || awaddr_reg == ADDR_PERIOD;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awaddr_reg <= ADDR_CTRL;
      wdata_reg <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awready_reg <= !aw_got_next;
      wready_reg <= !w_got_next;
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read mux; unmapped offsets answer zero with an error response.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL: rd_word = AXI_DW'(ctrl_reg);
      ADDR_VAL_LOW: rd_word = AXI_DW'(val_low_reg);
      ADDR_VAL_HIGH: rd_word = AXI_DW'(val_high_reg);
      ADDR_STATUS: begin
        rd_word[STAT_FLAG_BIT] = flag_reg;
        rd_word[STAT_PIN_BIT] = pin_sync_reg;
        rd_word[STAT_PEND_BIT] = pend_reg;
      end
      ADDR_PERIOD: rd_word = AXI_DW'(period_reg);
      default: rd_ok = 1'b0;
    endcase
  end

  assign ar_take = s_axi_arvalid && arready_reg;
  assign rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      arready_reg <= !rvalid_next;
      rvalid_reg <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= rd_word;
        rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign module_io_pin_out = pin_out_reg;
  assign module_io_pin_oe = pin_oe_reg;
  assign module_event_flag = flag_reg;
  assign special_trigger = trig_reg;
  assign timer_one_clear = t1_clear_reg;
  assign timer_two_clear = t2_clear_reg;

  // Checks on the behaviour above.
  property p_cap_value;
    @(posedge aclk) disable iff (!aresetn)
    cap_evt |=> {val_high_reg, val_low_reg} == $past(timer_one_count);
  endproperty
  a_cap_value: assert property (p_cap_value) else $error("capture value wrong");

  property p_flag_set;
    @(posedge aclk) disable iff (!aresetn)
    (cap_evt || cmp_hit) |=> module_event_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event flag not set");

  property p_flag_hold;
    @(posedge aclk) disable iff (!aresetn)
    (module_event_flag && !flag_clear) |=> module_event_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("event flag lost");

  property p_presc_zero;
    @(posedge aclk) disable iff (!aresetn)
    !is_cap |=> presc_reg == PRESC_ZERO;
  endproperty
  a_presc_zero: assert property (p_presc_zero) else $error("prescaler not cleared");

  property p_trig;
    @(posedge aclk) disable iff (!aresetn)
    trig_hit |=> special_trigger ##1 !special_trigger;
  endproperty
  a_trig: assert property (p_trig) else $error("special trigger wrong");

  property p_t1_clear;
    @(posedge aclk) disable iff (!aresetn)
    timer_one_clear |-> $past(pend_reg) && $past(timer_one_tick) && !$past(wr_low);
  endproperty
  a_t1_clear: assert property (p_t1_clear) else $error("timer one clear unexpected");

  property p_released;
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_reg.mode == MODE_OFF || ctrl_reg.mode == MODE_CMP_SWI) [*2] |-> !module_io_pin_oe;
  endproperty
  a_released: assert property (p_released) else $error("pin driven while released");

  property p_pwm_ro;
    @(posedge aclk) disable iff (!aresetn)
    (wr_high && is_pwm && !cap_evt && !period_roll) |=> $stable(val_high_reg);
  endproperty
  a_pwm_ro: assert property (p_pwm_ro) else $error("duty buffer written");

  property p_roll;
    @(posedge aclk) disable iff (!aresetn)
    period_roll |=> timer_two_clear && duty_latch_reg == $past(ctrl_reg.duty_low)
      && module_io_pin_out == ($past(duty_next) != DUTY_ZERO);
  endproperty
  a_roll: assert property (p_roll) else $error("period end wrong");

  property p_duty_clr;
    @(posedge aclk) disable iff (!aresetn)
    (duty_match && !period_roll) |=> !module_io_pin_out;
  endproperty
  a_duty_clr: assert property (p_duty_clr) else $error("pin not cleared at duty");
endmodule // ccpu_unit
`default_nettype wire

/* ccpu_far_end.sv */
`default_nettype none
// Far side of the unit: both timers and whatever drives the pin from outside.
module ccpu_far_end (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hold,
  input wire logic [7:0] period,
  input wire logic ext_level,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic t1_clear,
  output logic [15:0] t1_count,
  output logic t1_tick,
  output logic [7:0] t2_count,
  output logic [1:0] tb_low,
  output logic t2_inc,
  output logic pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] div_reg;

  // The pin level comes from the unit while it drives, otherwise from the outside source.
  assign pin_in = pin_oe ? pin_out : ext_level;
  // Timer one ticks on a divided clock, never on the system clock itself.
  assign t1_tick = (div_reg == 4'hF);
  assign t2_inc = (tb_low == 2'h3);

  // Timer one counts in step with the unit's clock; hold freezes it for exact captures.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 4'h0;
      t1_count <= 16'h0000;
    end else begin
      div_reg <= div_reg + 4'h1;
      if (t1_clear) begin
        t1_count <= 16'h0000;
      end else if (t1_tick && !hold) begin
        t1_count <= t1_count + 16'h0001;
      end
    end
  end

  // Timer two wraps at its period limit; the low time-base bits run at the system clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb_low <= 2'h0;
      t2_count <= 8'h00;
    end else begin
      tb_low <= tb_low + 2'h1;
      if (t2_inc) begin
        t2_count <= (t2_count == period) ? 8'h00 : t2_count + 8'h01;
      end
    end
  end
endmodule // ccpu_far_end
`default_nettype wire

/* tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ccpu_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, t1_tick, t2_inc, sleep, hold, ext;
  logic pin_in, pin_out, pin_oe, flag, trig, t1_clr, t2_clr;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [AXI_DW-1:0] wdata, rdata;
  logic [AXI_SW-1:0] wstrb;
  logic [1:0] bresp, rresp, tb_low;
  logic [T1_W-1:0] t1;
  logic [BYTE_W-1:0] t2, period;
  int failures, checks, cyc, trig_n, clr_n, t2c_n, trig_at, clr_at;

  ccpu_unit u_ccpu_unit (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_one_count(t1), .timer_one_tick(t1_tick), .timer_two_count(t2),
    .time_base_low(tb_low), .timer_two_inc(t2_inc), .sleep_active(sleep),
    .module_io_pin_in(pin_in), .module_io_pin_out(pin_out), .module_io_pin_oe(pin_oe),
    .module_event_flag(flag), .special_trigger(trig), .timer_one_clear(t1_clr),
    .timer_two_clear(t2_clr));

  ccpu_far_end u_ccpu_far_end (.aclk(aclk), .aresetn(aresetn), .hold(hold),
    .period(period), .ext_level(ext), .pin_out(pin_out), .pin_oe(pin_oe),
    .t1_clear(t1_clr), .t1_count(t1), .t1_tick(t1_tick), .t2_count(t2),
    .tb_low(tb_low), .t2_inc(t2_inc), .pin_in(pin_in));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic conclude();
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Pulses are tallied here so scenarios can judge counts and order afterwards.
  always @(posedge aclk) begin
    cyc++;
    if (trig === 1'b1) begin
      trig_n++;
      trig_at = cyc;
    end
    if (t1_clr === 1'b1) begin
      clr_n++;
      clr_at = cyc;
    end
    if (t2_clr === 1'b1) begin
      t2c_n++;
    end
    if (cyc == 40000) begin
      failures++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address and data are offered together; each is dropped at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic mode(input logic [3:0] m);
    wr(ADDR_CTRL, {28'h000_0000, m}, RESP_OKAY);
  endtask

  task automatic clr_flag();
    wr(ADDR_STATUS, 32'h0000_0001, RESP_OKAY);
  endtask

  // High byte first, so a half-written value never equals the final one.
  task automatic set_val(input logic [15:0] v);
    wr(ADDR_VAL_HIGH, {24'h00_0000, v[15:8]}, RESP_OKAY);
    wr(ADDR_VAL_LOW, {24'h00_0000, v[7:0]}, RESP_OKAY);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge aclk);
      ext <= 1'b1;
      repeat (4) @(posedge aclk);
      ext <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    repeat (8) @(posedge aclk);
  endtask

  task automatic high(output int h);
    h = 0;
    repeat (16) begin
      @(posedge aclk);
      if (pin_out === 1'b1) h++;
    end
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(ADDR_CTRL, d, r);
    chk("ctrl reset", 32'h0000_0000, d);
    rd(8'h14, d, r);
    chk("unmapped rresp", RESP_SLVERR, r);
    chk("unmapped rdata", 32'h0000_0000, d);
    wr(8'h14, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(ADDR_PERIOD, 32'h0000_0003, RESP_OKAY);
    rd(ADDR_PERIOD, d, r);
    chk("period", 32'h0000_0003, d);
  endtask

  // Two captures with no read between; only the later count may remain.
  task automatic t_capture();
    logic [31:0] d, lo;
    logic [1:0] r;
    logic [15:0] t;
    hold <= 1'b1;
    mode(MODE_CAP_RISE);
    clr_flag();
    pulses(1);
    hold <= 1'b0;
    repeat (40) @(posedge aclk);
    hold <= 1'b1;
    repeat (2) @(posedge aclk);
    t = t1;
    pulses(1);
    repeat (60) @(posedge aclk);
    chk("flag sticky", 1, flag);
    rd(ADDR_VAL_LOW, lo, r);
    rd(ADDR_VAL_HIGH, d, r);
    chk("capture", {16'h0000, t}, {16'h0000, d[7:0], lo[7:0]});
    rd(ADDR_STATUS, d, r);
    chk("status flag", 1, d[STAT_FLAG_BIT]);
    clr_flag();
    chk("flag cleared", 0, flag);
    hold <= 1'b0;
  endtask

  task automatic t_presc();
    mode(MODE_CAP_FALL);
    clr_flag();
    ext <= 1'b1;
    repeat (10) @(posedge aclk);
    chk("fall on rise", 0, flag);
    ext <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("fall", 1, flag);
    mode(MODE_OFF);
    mode(MODE_CAP_RISE4);
    clr_flag();
    pulses(3);
    chk("rise4 early", 0, flag);
    pulses(1);
    chk("rise4", 1, flag);
    clr_flag();
    pulses(2);
    mode(MODE_OFF);
    mode(MODE_CAP_RISE4);
    clr_flag();
    pulses(3);
    chk("prescaler cleared", 0, flag);
    mode(MODE_OFF);
    mode(MODE_CAP_RISE16);
    clr_flag();
    pulses(15);
    chk("rise16 early", 0, flag);
    pulses(1);
    chk("rise16", 1, flag);
    mode(MODE_OFF);
  endtask

  // Set, clear, toggle, software-interrupt and reserved code 1 each see one match entry with the timer frozen on a known count.
  task automatic t_compare();
    logic [3:0] ms [5] = '{MODE_CMP_SET, MODE_CMP_CLEAR, MODE_CMP_TOGGLE, MODE_CMP_SWI, 4'h1};
    logic fl [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic oe [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    logic pn [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [15:0] t;
    hold <= 1'b1;
    repeat (2) @(posedge aclk);
    t = t1;
    for (int i = 0; i < 5; i++) begin
      set_val(~t);
      mode(ms[i]);
      clr_flag();
      set_val(t);
      repeat (4) @(posedge aclk);
      chk("cmp flag", fl[i], flag);
      chk("cmp oe", oe[i], pin_oe);
      if (oe[i]) chk("cmp pin", pn[i], pin_out);
    end
    sleep <= 1'b1;
    set_val(~t);
    mode(MODE_CMP_SWI);
    clr_flag();
    set_val(t);
    repeat (4) @(posedge aclk);
    chk("sleep flag", 0, flag);
    sleep <= 1'b0;
    mode(MODE_CMP_SET);
    mode(MODE_OFF);
    repeat (2) @(posedge aclk);
    chk("off oe", 0, pin_oe);
    hold <= 1'b0;
  endtask

  task automatic t_trig();
    logic [15:0] t;
    mode(MODE_CMP_TRIG);
    clr_flag();
    trig_n = 0;
    clr_n = 0;
    set_val(t1 + 16'h0008);
    repeat (200) @(posedge aclk);
    chk("trig count", 1, trig_n);
    chk("t1 clear count", 1, clr_n);
    chk("clear after trig", 1, clr_at > trig_at && clr_at - trig_at <= 18);
    chk("trig flag", 1, flag);
    chk("trig oe", 0, pin_oe);
    clr_flag();
    trig_n = 0;
    clr_n = 0;
    t = t1 + 16'h0004;
    set_val(t);
    while (trig_n == 0) @(posedge aclk);
    wr(ADDR_VAL_LOW, {24'h00_0000, ~t[7:0]}, RESP_OKAY);
    repeat (60) @(posedge aclk);
    chk("clear cancelled", 0, clr_n);
    mode(MODE_OFF);
  endtask

  // Pulse widths are compared between duties, so the output register's lag cancels out.
  task automatic t_pwm();
    int h6, h10, h0;
    logic [31:0] d;
    logic [1:0] r;
    wr(ADDR_VAL_LOW, 32'h0000_0001, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_002C, RESP_OKAY);
    repeat (40) @(posedge aclk);
    high(h6);
    chk("pwm oe", 1, pin_oe);
    #1 t2c_n = 0;
    repeat (32) @(posedge aclk);
    #1 chk("t2 clears", 2, t2c_n);
    wr(ADDR_VAL_HIGH, 32'h0000_00AA, RESP_OKAY);
    rd(ADDR_VAL_HIGH, d, r);
    chk("high read only", 32'h0000_0001, d);
    wr(ADDR_VAL_LOW, 32'h0000_0002, RESP_OKAY);
    repeat (40) @(posedge aclk);
    high(h10);
    chk("duty step", 4, h10 - h6);
    wr(ADDR_VAL_LOW, 32'h0000_0000, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_000C, RESP_OKAY);
    repeat (40) @(posedge aclk);
    high(h0);
    chk("duty zero", 0, h0);
    mode(MODE_OFF);
    repeat (2) @(posedge aclk);
    chk("pwm off oe", 0, pin_oe);
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, sleep, hold, ext} = 8'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    period = 8'h03;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_capture();
    t_presc();
    t_compare();
    t_trig();
    t_pwm();
    conclude();
  end
endmodule // tb_top
`default_nettype wire
